// ### shared/prr_params.svh
// Constants of the page-0 upper result bank: addresses, control fields,
// reset values and default sizes.
// Assumes inclusion by bare name from any design or bench file.
`ifndef PRR_PARAMS_SVH
`define PRR_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define PRR_DATA_W        24
`define PRR_ADDR_W        5
`define PRR_PAGE_W        7

// ----------------------------------------
// Register addresses within a page
// ----------------------------------------
`define PRR_ADDR_PEAK_CUR 5'h16
`define PRR_ADDR_PEAK_VOL 5'h17
`define PRR_ADDR_TRIG_Q   5'h18
`define PRR_ADDR_PF       5'h19
`define PRR_ADDR_APPARENT 5'h1B
`define PRR_ADDR_CTRL     5'h1C
`define PRR_ADDR_HARM_P   5'h1D
`define PRR_ADDR_FUND_P   5'h1E
`define PRR_ADDR_TOP      5'h1F

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define PRR_CTRL_STOP     8
`define PRR_CTRL_IRQ_OD   4
`define PRR_CTRL_PCLK_OFF 2
`define PRR_CTRL_OSC_OFF  1
`define PRR_CTRL_RESET    24'h000000
`define PRR_PAGE_RESET    7'h00
`define PRR_PAGE_RESULTS  7'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define PRR_PCLK_HALF     1

`endif

// ### shared/prr_pkg.sv
// Types shared by the result bank modules.
// Assumes nothing beyond a SystemVerilog compiler.
package prr_pkg;

  // Result sequencer states
  typedef enum logic [1:0] {
    PRR_IDLE,
    PRR_PREP,
    PRR_CALC,
    PRR_COMMIT
  } prr_state_t;

endpackage

// ### shared/prr_meas_if.sv
// Carrier between the bank and its peak tracker.
// Assumes one clock domain; samples and clear are single-cycle qualified.
`timescale 1ns/1ps
`include "prr_params.svh"
interface prr_meas_if #(parameter int W = `PRR_DATA_W);
  logic                sample_valid;  // New instantaneous sample pair
  logic signed [W-1:0] cur;           // Instantaneous current
  logic signed [W-1:0] vol;           // Instantaneous voltage
  logic                clear;         // Start of a new computation cycle
  logic signed [W-1:0] peak_cur;      // Largest-magnitude current so far
  logic signed [W-1:0] peak_vol;      // Largest-magnitude voltage so far

  modport owner (output sample_valid, cur, vol, clear, input peak_cur, peak_vol);
  modport tracker (input sample_valid, cur, vol, clear, output peak_cur, peak_vol);
endinterface

// ### core/prr_peak_track.sv
// Peak magnitude trackers for the current and voltage channels.
// Assumes samples and the cycle clear arrive on sys_clk.
`timescale 1ns/1ps
`include "prr_params.svh"
module prr_peak_track #(
  parameter int W = `PRR_DATA_W  // Sample width
) (
  // Clock and reset
  input  wire logic    sys_clk,
  input  wire logic    nrst,
  // Samples in, peaks out
  prr_meas_if.tracker  mi
);

  logic signed [W-1:0] smp  [2];  // Channel samples, 0 current, 1 voltage
  logic signed [W-1:0] peak [2];  // Channel peaks

  // Magnitude one bit wider so that minus one compares correctly
  function automatic logic [W:0] mag(input logic signed [W-1:0] x);
    logic signed [W:0] e;
    e = {x[W-1], x};
    return (e < 0) ? -e : e;
  endfunction

  assign smp[0]      = mi.cur;
  assign smp[1]      = mi.vol;
  assign mi.peak_cur = peak[0];
  assign mi.peak_vol = peak[1];

  // ----------------------------------------
  // One tracker per channel
  // ----------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_chan
    // Clear restarts the cycle; a sample in that cycle seeds it
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        peak[c] <= '0;
      end else if (mi.clear) begin
        peak[c] <= mi.sample_valid ? smp[c] : '0;
      end else if (mi.sample_valid && (mag(smp[c]) > mag(peak[c]))) begin
        peak[c] <= smp[c];
      end
    end
  end

endmodule // prr_peak_track

// ### core/prr_top.sv
// Upper page-0 result bank of a single-phase power meter: peak values,
// power results, control register and page select.
// Assumes the serial framer presents one decoded access per strobe and
// that the measurement engine flags each computation cycle end.
//
// Notes on behaviour
// - Peak registers hold largest-magnitude sample last cycle
// - Trig reactive power is unsigned fraction below one
// - Power factor is active over apparent, signed
// - Apparent power is RMS voltage times RMS current
// - Harmonic power is active minus fundamental power
// - Fundamental power multiplies voltage and current DFTs
// - Top address read returns fundamental reactive power
// - Top address write loads seven-bit page, reset zero
// - Control resets zero; bit 8 stops auto-boot
// - Control bit 4 makes interrupt pin open drain
// - Control bit 2 stops processor clock output
// - Control bit 1 disables crystal oscillator
// - Auto line-frequency mode supplies the DFT frequency
`timescale 1ns/1ps
`include "prr_params.svh"
module prr_top #(
  parameter int W         = `PRR_DATA_W,    // Result word width
  parameter int PCLK_HALF = `PRR_PCLK_HALF  // Cycles per processor clock half period
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  // Instantaneous samples
  input  wire logic                      sample_valid,
  input  wire logic signed [W-1:0]       inst_current,
  input  wire logic signed [W-1:0]       inst_voltage,
  // Engine results for the ending cycle
  input  wire logic                      cycle_end,
  input  wire logic [W-1:0]              v_rms,
  input  wire logic [W-1:0]              i_rms,
  input  wire logic signed [W-1:0]       p_active,
  input  wire logic signed [W-1:0]       v_fund_re,
  input  wire logic signed [W-1:0]       v_fund_im,
  input  wire logic signed [W-1:0]       i_fund_re,
  input  wire logic signed [W-1:0]       i_fund_im,
  // Line frequency
  input  wire logic                      auto_line_freq_enable,
  input  wire logic                      freq_meas_valid,
  input  wire logic signed [W-1:0]       freq_meas_ratio,
  input  wire logic signed [W-1:0]       freq_ratio_host,
  output logic signed [W-1:0]            dft_freq_ratio,
  // Register access from the serial framer
  input  wire logic [`PRR_ADDR_W-1:0]    reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic [W-1:0]              reg_wdata,
  input  wire logic                      reg_rd,
  output logic [W-1:0]                   reg_rdata,
  output logic                           reg_rd_valid,
  output logic                           reg_rd_hit,
  output logic [`PRR_PAGE_W-1:0]         register_page_select,
  // Control outputs
  output logic                           autoboot_stop,
  output logic                           crystal_osc_disable,
  output logic                           processor_clock_output,
  // Interrupt pin, active low
  input  wire logic                      irq_req,
  output logic                           irq_n_o,
  output logic                           irq_n_oe,
  // Status
  output logic                           results_updated
);

  // ----------------------------------------
  // Local constants and checks
  // ----------------------------------------
  localparam int FRAC = W - 1;  // Binary point right of the MSB
  localparam logic [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};  // Just below one
  localparam logic [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};  // Minus one
  localparam logic [$clog2(W)-1:0] LAST_STEP = ($clog2(W))'(W - 1);
  localparam logic [15:0] PCLK_LAST = 16'(PCLK_HALF - 1);

  // Control fields must fit and divider must count
  if (W <= `PRR_CTRL_STOP || W > 32 || PCLK_HALF < 1 || PCLK_HALF > 65535) begin : g_bad
    $error("prr_top: unsupported W or PCLK_HALF");
  end

  // Signed product shifted to the fraction and clipped
  function automatic logic [W-1:0] sat_frac(input logic signed [2*W+1:0] v);
    logic signed [2*W+1:0] s;
    s = v >>> FRAC;
    if (s[2*W+1:W-1] == {(W+3){s[2*W+1]}}) begin
      return s[W-1:0];
    end
    return s[2*W+1] ? SMIN : SMAX;
  endfunction

  // ----------------------------------------
  // Registers and working state
  // ----------------------------------------
  prr_pkg::prr_state_t state_reg;        // Result sequencer
  logic [W-1:0]        ctrl_reg;         // Device control
  logic [W-1:0]        peak_cur_reg;     // Published peak current
  logic [W-1:0]        peak_vol_reg;     // Published peak voltage
  logic [W-1:0]        trig_q_reg;       // Published trig reactive power
  logic [W-1:0]        pf_reg;           // Published power factor
  logic [W-1:0]        apparent_reg;     // Published apparent power
  logic [W-1:0]        harm_p_reg;       // Published harmonic power
  logic [W-1:0]        fund_p_reg;       // Published fundamental power
  logic [W-1:0]        fund_q_reg;       // Published fundamental reactive
  logic signed [W-1:0] op_v_re, op_v_im; // Latched voltage DFT
  logic signed [W-1:0] op_i_re, op_i_im; // Latched current DFT
  logic [W-1:0]        op_v_rms;         // Latched RMS voltage
  logic [W-1:0]        op_i_rms;         // Latched RMS current
  logic signed [W-1:0] op_p;             // Latched active power
  logic [W-1:0]        snap_cur;         // Peak current at cycle end
  logic [W-1:0]        snap_vol;         // Peak voltage at cycle end
  logic [W-1:0]        s_work;           // Apparent power result
  logic [W-1:0]        pf_work;          // Fundamental power result
  logic [W-1:0]        qf_work;          // Fundamental reactive result
  logic [W-1:0]        ph_work;          // Harmonic power result
  logic [W:0]          div_rem;          // Division remainder
  logic [W-1:0]        div_q;            // Division quotient
  logic                div_neg;          // Power factor sign
  logic [1:0]          div_special;      // 0 divide, 1 zero, 2 clip
  logic [2*W-1:0]      sq_rad;           // Radicand S^2 - P^2
  logic [W-1:0]        sq_root;          // Root being built
  logic [W-1:0]        sq_bit;           // Trial bit of the root
  logic [$clog2(W)-1:0] step_reg;        // Iteration counter
  logic [15:0]         pclk_cnt;         // Processor clock divider

  // ----------------------------------------
  // Combinational arithmetic
  // ----------------------------------------
  logic [2*W-1:0]        s_prod;   // RMS product
  logic signed [2*W+1:0] pf_sum;   // Re*Re + Im*Im
  logic signed [2*W+1:0] qf_sum;   // Im*Re - Re*Im
  logic signed [W:0]     ph_diff;  // Active minus fundamental
  logic [W-1:0]          p_abs;    // Active power magnitude
  logic [2*W-1:0]        s_sq;     // Apparent squared
  logic [2*W-1:0]        p_sq;     // Active squared
  logic [W:0]            rem_sh;   // Remainder doubled
  logic [W-1:0]          sq_try;   // Trial root
  logic [2*W-1:0]        try_sq;   // Trial root squared

  assign s_prod  = op_v_rms * op_i_rms;
  assign pf_sum  = (2*W+2)'(op_v_re * op_i_re) + (2*W+2)'(op_v_im * op_i_im);
  assign qf_sum  = (2*W+2)'(op_v_im * op_i_re) - (2*W+2)'(op_v_re * op_i_im);
  assign ph_diff = {op_p[W-1], op_p} - {pf_work[W-1], pf_work};
  assign p_abs   = op_p[W-1] ? W'(-op_p) : W'(op_p);
  assign s_sq    = s_work * s_work;
  assign p_sq    = p_abs * p_abs;
  assign rem_sh  = {div_rem[W-1:0], 1'b0};
  assign sq_try  = sq_root | sq_bit;
  assign try_sq  = sq_try * sq_try;

  // ----------------------------------------
  // Peak tracker
  // ----------------------------------------
  prr_meas_if #(.W(W)) meas ();

  assign meas.sample_valid = sample_valid;
  assign meas.cur          = inst_current;
  assign meas.vol          = inst_voltage;
  assign meas.clear        = cycle_end && (state_reg == prr_pkg::PRR_IDLE);

  prr_peak_track #(.W(W)) u_peak (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .mi      (meas)
  );

  // ----------------------------------------
  // Result sequencer
  // ----------------------------------------
  // Cycle end accepted only when idle; ones arriving while busy are dropped
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= prr_pkg::PRR_IDLE;
      step_reg  <= '0;
    end else begin
      unique case (state_reg)
        prr_pkg::PRR_IDLE: begin
          if (cycle_end) begin
            state_reg <= prr_pkg::PRR_PREP;
          end
        end
        prr_pkg::PRR_PREP: begin
          state_reg <= prr_pkg::PRR_CALC;
          step_reg  <= '0;
        end
        prr_pkg::PRR_CALC: begin
          if (step_reg == LAST_STEP) begin
            state_reg <= prr_pkg::PRR_COMMIT;
          end else begin
            step_reg <= step_reg + 1'b1;
          end
        end
        prr_pkg::PRR_COMMIT: begin
          state_reg <= prr_pkg::PRR_IDLE;
        end
      endcase
    end
  end

  // Operands and peaks frozen at the cycle end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {op_v_re, op_v_im, op_i_re, op_i_im} <= '0;
      {op_v_rms, op_i_rms, op_p}           <= '0;
      {snap_cur, snap_vol}                 <= '0;
    end else if (meas.clear) begin
      op_v_re  <= v_fund_re;
      op_v_im  <= v_fund_im;
      op_i_re  <= i_fund_re;
      op_i_im  <= i_fund_im;
      op_v_rms <= v_rms;
      op_i_rms <= i_rms;
      op_p     <= p_active;
      snap_cur <= meas.peak_cur;
      snap_vol <= meas.peak_vol;
    end
  end

  // Apparent and fundamental powers ready first; divide, root and harmonic use them later
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {s_work, pf_work, qf_work} <= '0;
    end else if (state_reg == prr_pkg::PRR_PREP) begin
      s_work  <= (|s_prod[2*W-1:W+FRAC-1]) ? SMAX : s_prod[FRAC +: W];
      pf_work <= sat_frac(pf_sum);
      qf_work <= sat_frac(qf_sum);
    end
  end

  // Harmonic power once the fundamental is known
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ph_work <= '0;
    end else if (state_reg == prr_pkg::PRR_CALC && step_reg == '0) begin
      if (ph_diff[W] != ph_diff[W-1]) begin
        ph_work <= ph_diff[W] ? SMIN : SMAX;
      end else begin
        ph_work <= ph_diff[W-1:0];
      end
    end
  end

  // Restoring division of active by apparent power
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_rem     <= '0;
      div_q       <= '0;
      div_neg     <= 1'b0;
      div_special <= 2'h0;
    end else if (state_reg == prr_pkg::PRR_CALC && step_reg == '0) begin
      div_rem     <= {1'b0, p_abs};
      div_q       <= '0;
      div_neg     <= op_p[W-1];
      div_special <= (s_work == '0) ? 2'h1 : ((p_abs >= s_work) ? 2'h2 : 2'h0);
    end else if (state_reg == prr_pkg::PRR_CALC) begin
      if (rem_sh >= {1'b0, s_work}) begin
        div_rem <= rem_sh - {1'b0, s_work};
        div_q   <= {div_q[W-2:0], 1'b1};
      end else begin
        div_rem <= rem_sh;
        div_q   <= {div_q[W-2:0], 1'b0};
      end
    end
  end

  // Bit-serial square root of S^2 - P^2
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sq_rad  <= '0;
      sq_root <= '0;
      sq_bit  <= '0;
    end else if (state_reg == prr_pkg::PRR_PREP) begin
      sq_root <= '0;
      sq_bit  <= SMIN >> 1;  // Root stays below one, so start one bit lower
    end else if (state_reg == prr_pkg::PRR_CALC && step_reg == '0) begin
      sq_rad  <= (p_sq > s_sq) ? '0 : s_sq - p_sq;
    end else if (state_reg == prr_pkg::PRR_CALC) begin
      if (try_sq <= sq_rad) begin
        sq_root <= sq_try;
      end
      sq_bit <= sq_bit >> 1;
    end
  end

  // ----------------------------------------
  // Published results
  // ----------------------------------------
  // All results change in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {peak_cur_reg, peak_vol_reg, trig_q_reg, pf_reg} <= '0;
      {apparent_reg, harm_p_reg, fund_p_reg, fund_q_reg} <= '0;
      results_updated <= 1'b0;
    end else begin
      results_updated <= (state_reg == prr_pkg::PRR_COMMIT);
      if (state_reg == prr_pkg::PRR_COMMIT) begin
        peak_cur_reg <= snap_cur;
        peak_vol_reg <= snap_vol;
        trig_q_reg   <= {1'b0, sq_root[W-2:0]};
        apparent_reg <= s_work;
        harm_p_reg   <= ph_work;
        fund_p_reg   <= pf_work;
        fund_q_reg   <= qf_work;
        unique case (div_special)
          2'h1:    pf_reg <= '0;
          2'h2:    pf_reg <= div_neg ? SMIN : SMAX;
          default: pf_reg <= div_neg ? W'(-div_q) : div_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Host writes
  // ----------------------------------------
  // Page select loads from the top address on any page
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      register_page_select <= `PRR_PAGE_RESET;
    end else if (reg_wr && reg_addr == `PRR_ADDR_TOP) begin
      register_page_select <= reg_wdata[`PRR_PAGE_W-1:0];
    end
  end

  // Control keeps its defined bits; result addresses ignore writes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg <= `PRR_CTRL_RESET;
    end else if (reg_wr && reg_addr == `PRR_ADDR_CTRL
                 && register_page_select == `PRR_PAGE_RESULTS) begin
      ctrl_reg <= '0;
      ctrl_reg[`PRR_CTRL_STOP]  <= reg_wdata[`PRR_CTRL_STOP];
      ctrl_reg[`PRR_CTRL_IRQ_OD]   <= reg_wdata[`PRR_CTRL_IRQ_OD];
      ctrl_reg[`PRR_CTRL_PCLK_OFF] <= reg_wdata[`PRR_CTRL_PCLK_OFF];
      ctrl_reg[`PRR_CTRL_OSC_OFF]  <= reg_wdata[`PRR_CTRL_OSC_OFF];
    end
  end

  assign autoboot_stop       = ctrl_reg[`PRR_CTRL_STOP];
  assign crystal_osc_disable = ctrl_reg[`PRR_CTRL_OSC_OFF];

  // ----------------------------------------
  // Host reads
  // ----------------------------------------
  logic [W-1:0] rd_mux;  // Addressed word
  logic         rd_map;  // Address belongs to this bank

  // Decode of page-0 upper addresses
  always_comb begin
    rd_map = (register_page_select == `PRR_PAGE_RESULTS);
    unique case (reg_addr)
      `PRR_ADDR_PEAK_CUR: rd_mux = peak_cur_reg;
      `PRR_ADDR_PEAK_VOL: rd_mux = peak_vol_reg;
      `PRR_ADDR_TRIG_Q:   rd_mux = trig_q_reg;
      `PRR_ADDR_PF:       rd_mux = pf_reg;
      `PRR_ADDR_APPARENT: rd_mux = apparent_reg;
      `PRR_ADDR_CTRL:     rd_mux = ctrl_reg;
      `PRR_ADDR_HARM_P:   rd_mux = harm_p_reg;
      `PRR_ADDR_FUND_P:   rd_mux = fund_p_reg;
      `PRR_ADDR_TOP:      rd_mux = fund_q_reg;
      default: begin
        rd_mux = '0;
        rd_map = 1'b0;
      end
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata    <= '0;
      reg_rd_valid <= 1'b0;
      reg_rd_hit   <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      reg_rd_hit   <= reg_rd && rd_map;
      if (reg_rd) begin
        reg_rdata <= rd_map ? rd_mux : '0;
      end
    end
  end

  // ----------------------------------------
  // Processor clock output
  // ----------------------------------------
  // Divider toggles the pin; disabled it parks low
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pclk_cnt               <= '0;
      processor_clock_output <= 1'b0;
    end else if (ctrl_reg[`PRR_CTRL_PCLK_OFF]) begin
      pclk_cnt               <= '0;
      processor_clock_output <= 1'b0;
    end else if (pclk_cnt == PCLK_LAST) begin
      pclk_cnt               <= '0;
      processor_clock_output <= ~processor_clock_output;
    end else begin
      pclk_cnt <= pclk_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  // Open drain pulls low only; normal mode always drives
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_n_o  <= 1'b1;
      irq_n_oe <= 1'b0;
    end else if (ctrl_reg[`PRR_CTRL_IRQ_OD]) begin
      irq_n_o  <= 1'b0;
      irq_n_oe <= irq_req;
    end else begin
      irq_n_o  <= ~irq_req;
      irq_n_oe <= 1'b1;
    end
  end

  // ----------------------------------------
  // DFT frequency source
  // ----------------------------------------
  // Auto mode follows measurements; otherwise the host ratio
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dft_freq_ratio <= '0;
    end else if (!auto_line_freq_enable) begin
      dft_freq_ratio <= freq_ratio_host;
    end else if (freq_meas_valid) begin
      dft_freq_ratio <= freq_meas_ratio;
    end
  end

endmodule // prr_top

// ### tb/prr_top_properties.sv
// Checker on the ports of the result bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module prr_top_checker #(parameter int W = 24, parameter int PCLK_HALF = 1) (
  // Clock and reset
  input wire logic sys_clk, nrst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [W-1:0] reg_wdata,
  input wire logic reg_wr, reg_rd, reg_rd_valid, reg_rd_hit,
  input wire logic [6:0] register_page_select,
  // Control, pins and status
  input wire logic autoboot_stop, crystal_osc_disable, processor_clock_output,
  input wire logic irq_req, irq_n_o, irq_n_oe, cycle_end, results_updated,
  input wire logic auto_line_freq_enable,
  input wire logic signed [W-1:0] freq_ratio_host, dft_freq_ratio
);
  // ----------------------------------------
  // Helper decode
  // ----------------------------------------
  logic [6:0] wr_page;
  logic       ctl_wr;
  logic [1:0] ctl_bits;
  assign wr_page  = reg_wdata[6:0];
  assign ctl_wr   = reg_wr && reg_addr == 5'h1C && register_page_select == 7'h00;
  assign ctl_bits = {reg_wdata[8], reg_wdata[1]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_read_answer: assert property ($past(nrst) |-> reg_rd_valid == $past(reg_rd))
    else $error("read answer late or spurious");
  chk_page_gate: assert property (reg_rd && register_page_select != 7'h00 |=> !reg_rd_hit)
    else $error("hit on foreign page");
  chk_page_load: assert property (reg_wr && reg_addr == 5'h1F |=> register_page_select == $past(wr_page))
    else $error("page not loaded");
  chk_update_delay: assert property (results_updated |-> $past(cycle_end, 27))
    else $error("update at wrong time");
  chk_update_pulse: assert property (results_updated |=> !results_updated)
    else $error("update pulse too long");
  chk_ctrl_bits: assert property (ctl_wr |=> {autoboot_stop, crystal_osc_disable} == $past(ctl_bits))
    else $error("control outputs wrong");
  chk_pclk_stop: assert property (ctl_wr && reg_wdata[2] |-> ##2 !processor_clock_output)
    else $error("processor clock still running");
  chk_irq_mode: assert property ($past(nrst) |-> (irq_n_oe && irq_n_o == !$past(irq_req))
    || (!irq_n_o && irq_n_oe == $past(irq_req)))
    else $error("interrupt pin wrong");
  chk_freq_host: assert property ($past(nrst) && !$past(auto_line_freq_enable)
    |-> dft_freq_ratio == $past(freq_ratio_host))
    else $error("frequency ratio wrong");
endmodule // prr_top_checker
bind prr_top prr_top_checker #(.W(W), .PCLK_HALF(PCLK_HALF)) chk_i (.sys_clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rd_valid, .reg_rd_hit, .register_page_select, .autoboot_stop, .crystal_osc_disable,
  .processor_clock_output, .irq_req, .irq_n_o, .irq_n_oe, .cycle_end, .results_updated,
  .auto_line_freq_enable, .freq_ratio_host, .dft_freq_ratio);

// ### tb/prr_host_model.sv
// Host side of the register port: one access at a time.
// Assumes the bench calls its tasks in sequence.
`timescale 1ns/1ps
module prr_host_model (
  input  wire logic   sys_clk,
  output logic [4:0]  reg_addr,
  output logic        reg_wr,
  output logic [23:0] reg_wdata,
  output logic        reg_rd
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  // One strobe cycle, then address and data are scrambled
  task automatic acc(input logic w, input logic [4:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
  endtask
  // Page chosen before other pages are reached
  task automatic pg(input logic [6:0] p); acc(1, 5'h1F, {17'h0, p}); endtask
endmodule // prr_host_model

// ### tb/prr_top_bench.sv
// Self-checking bench for the result bank.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ps
module prr_top_bench;
  logic sys_clk = 0, nrst = 0, sv = 0, ce = 0, afe = 0, fv = 0, irq = 0, wr, rd, rv, rh, ab, osc, pck, io, ioe, upd;
  logic signed [23:0] ic = 0, iv = 0, pa = 0, vre = 0, vim = 0, ire = 0, iim = 0, fm = 0, fh = 0, dft, p0, p1;
  logic [23:0] vr = 0, ir = 0, rdat, wd;
  logic [4:0] ad;
  logic [6:0] pgs;
  logic [24:0] expq[$];
  int error_cnt = 0, n_tests = 0, seed = 66995, cyc = 0;
  longint s, pf, qf, pfr, qt;
  always #12.5 sys_clk = ~sys_clk;
  prr_host_model host (.sys_clk, .reg_addr(ad), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd));
  prr_top uut (.sys_clk, .nrst, .sample_valid(sv), .inst_current(ic), .inst_voltage(iv), .cycle_end(ce),
    .v_rms(vr), .i_rms(ir), .p_active(pa), .v_fund_re(vre), .v_fund_im(vim), .i_fund_re(ire), .i_fund_im(iim),
    .auto_line_freq_enable(afe), .freq_meas_valid(fv), .freq_meas_ratio(fm), .freq_ratio_host(fh),
    .dft_freq_ratio(dft), .reg_addr(ad), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat),
    .reg_rd_valid(rv), .reg_rd_hit(rh), .register_page_select(pgs), .autoboot_stop(ab),
    .crystal_osc_disable(osc), .processor_clock_output(pck), .irq_req(irq), .irq_n_o(io), .irq_n_oe(ioe),
    .results_updated(upd));
  function automatic longint mag(longint x); return x < 0 ? -x : x; endfunction
  function automatic longint isq(longint x);
    longint r = 0;
    for (int b = 23; b >= 0; b--) if ((r | (64'd1 << b)) * (r | (64'd1 << b)) <= x) r |= 64'd1 << b;
    return r;
  endfunction
  task automatic chk(logic [24:0] got, logic [24:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rdx(logic [4:0] a, logic [24:0] e); expq.push_back(e); host.acc(0, a, 0); endtask
  // Read answers compared against the oldest note
  always @(negedge sys_clk) if (rv === 1'b1) chk({rh, rdat}, expq.pop_front());
  // Free random pins and the hang limit
  always @(posedge sys_clk) begin
    {irq, afe, fv} <= $random(seed);
    fm <= $random(seed);
    fh <= $random(seed);
    if (++cyc > 5000) begin
      error_cnt++;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1;
    rdx(5'h1C, 25'h1000000);
    host.acc(1, 5'h1C, 24'hFFFFFF);
    @(posedge sys_clk);
    repeat (4) @(negedge sys_clk) chk({ab, osc, pck, io}, 4'hC);
    rdx(5'h1C, 25'h1000116);
    host.acc(1, 5'h1C, 0);
    host.pg(7'h05);
    @(negedge sys_clk) chk(pgs, 7'h05);
    rdx(5'h19, 0);
    host.acc(1, 5'h1C, 24'h4);
    host.pg(0);
    rdx(5'h1C, 25'h1000000);
    repeat (2) begin
      p0 = 0;
      p1 = 0;
      for (int k = 0; k <= 40; k++) begin
        @(posedge sys_clk);
        if (sv && mag(ic) > mag(p0)) p0 = ic;
        if (sv && mag(iv) > mag(p1)) p1 = iv;
        sv <= k < 40;
        ic <= $random(seed);
        iv <= $random(seed);
      end
      {ce, vr, ir} <= {1'b1, 2'b01, 22'($random(seed)), 2'b01, 22'($random(seed))};
      {pa, vre, vim, ire, iim} <= {24'($random(seed) % 1048576), 24'($random(seed) % 32768),
        24'($random(seed) % 32768), 24'($random(seed) % 32768), 24'($random(seed) % 32768)};
      @(posedge sys_clk) ce <= 0;
      s = (longint'(vr) * ir) >> 23;
      pf = (longint'(vre) * ire + longint'(vim) * iim) >>> 23;
      qf = (longint'(vim) * ire - longint'(vre) * iim) >>> 23;
      pfr = (mag(pa) << 23) / s;
      pfr = pa < 0 ? -pfr : pfr;
      qt = isq(s * s - longint'(pa) * pa);
      repeat (26) @(posedge sys_clk);
      @(negedge sys_clk) chk(upd, 1);
      host.acc(1, 5'h16, 24'h5A5A5A);
      rdx(5'h16, {1'b1, p0});
      rdx(5'h17, {1'b1, p1});
      rdx(5'h18, {1'b1, qt[23:0]});
      rdx(5'h19, {1'b1, pfr[23:0]});
      rdx(5'h1A, 0);
      rdx(5'h1B, {1'b1, s[23:0]});
      rdx(5'h1D, {1'b1, 24'(pa - pf)});
      rdx(5'h1E, {1'b1, pf[23:0]});
      rdx(5'h1F, {1'b1, qf[23:0]});
    end
    repeat (4) @(posedge sys_clk);
    if (expq.size() != 0) error_cnt++;
    complete_run;
  end
endmodule // prr_top_bench
